/* File: hdl/usb_state_consts.vh */
`ifndef USB_STATE_CONSTS_VH
`define USB_STATE_CONSTS_VH
// register byte offsets
`define OFS_GLOBAL_STATE 8'h04
`define OFS_FUNC_ADDR 8'h08
`define OFS_IRQ_ENABLE 8'h10
`define OFS_IRQ_DISABLE 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_IRQ_STATUS 8'h1C
`define OFS_IRQ_CLEAR 8'h20
`define OFS_RESET_EP 8'h28
`define OFS_EP_CTRL0 8'h30
`define OFS_EP_CTRL7 8'h4C
`define OFS_TRANSCEIVER 8'h74
`define OFS_BUS_EVENT 8'h78
// global_state_reg fields
`define GS_ADDRESSED 0
`define GS_CONFIGURED 1
`define GS_SEND_RESUME 2
`define GS_RESUME_BUSY 3
`define GS_REMOTE_WAKE 4
// function_address_reg fields
`define FA_VALID 8
// irq bits
`define IRQ_EP_LAST 7
`define IRQ_SUSPEND 8
`define IRQ_RESUME 9
`define IRQ_WAKEUP 13
`define IRQ_BUS_RESET_END 12
// endpoint control fields
`define EP_ENABLE 15
`define EP_TYPE_LO 8
`define EP_TYPE_HI 10
`define EP_PKT_READY 4
// transceiver fields
`define TX_DISABLE 8
`define TX_PULLUP 9
// reset values
`define RST_GLOBAL_STATE 32'h0000_0010
`define RST_FUNC_ADDR 32'h0000_0100
`define RST_IRQ_MASK 32'h0000_1200
`define RST_TRANSCEIVER 32'h0000_0100
`define RST_EP_CTRL 32'h0000_0000
// timing
`define CLK_MHZ 125
`define SUSPEND_IDLE_US 3000
`define RESUME_K_US 2000
`endif

/* File: hdl/usb_ep_ctrl.v */
`timescale 1ns/1ps
`include "usb_state_consts.vh"
module usb_ep_ctrl (
    input wire clk_sys,
    input wire rst,
    input wire bus_reset_end,
    input wire ep_reset,
    input wire wr,
    input wire [31:0] wdata,
    output reg [31:0] ctrl
);
    // keeps enable, type and packet ready; bus reset end restores reset contents
    always @(posedge clk_sys) begin
        if (rst || bus_reset_end) begin
            ctrl <= `RST_EP_CTRL;
        end else if (wr) begin
            ctrl <= {16'h0000, wdata[`EP_ENABLE], 4'h0,
                     wdata[`EP_TYPE_HI:`EP_TYPE_LO], 3'h0, wdata[`EP_PKT_READY], 4'h0};
        end else if (ep_reset) begin
            // packet ready dropped; the rest of the register is kept
            ctrl[`EP_PKT_READY] <= 1'b0;
        end
    end
endmodule // usb_ep_ctrl

/* File: hdl/usb_device_state_control.v */
// Behaviour
// - State follows bus conditions or endpoint 0 standard requests.
// - Setting pullup_on connects the pull-up; device becomes powered.
// - Bus reset end sets an unmaskable flag, interrupts, enters default state.
// - Bus reset end restores irq mask and endpoint control registers.
// - Address state: addressed bit, address, valid bit; device answers there.
// - Idle bus sets suspend flag, masked interrupt; cleared only by irq clear.
// - While suspended, resume activity is detected through a two-flop synchronizer on clk_sys.
// - Bus resume sets the wake-up flag; interrupt if its mask bit is set.
// - Resume K state lasts between 1 and 15 ms.
// - Rising send_resume_bit, written 0 then 1, starts the K state.
// - Device generates and releases the K state without firmware help.
// - Send resume starts only from 0 and with remote_wake_enable set.
// - Writing 0 to addressed bit does nothing; only bus reset or clearing the pull-up bit leaves address state.
`timescale 1ns/1ps
`include "usb_state_consts.vh"
module usb_device_state_control #(
    parameter SUSPEND_CYCLES = `SUSPEND_IDLE_US * `CLK_MHZ,
    parameter RESUME_K_CYCLES = `RESUME_K_US * `CLK_MHZ
) (
    input wire clk_sys,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire bus_activity,
    input wire bus_reset_end,
    input wire resume_detect,
    output reg drive_k_state,
    output reg pullup_connected,
    output reg transceiver_off,
    output reg irq,
    output reg [6:0] device_address,
    output reg address_valid,
    output reg [1:0] device_state,
    output reg [7:0] endpoint_enables
);
    localparam ST_POWERED = 2'b00;
    localparam ST_DEFAULT = 2'b01;
    localparam ST_ADDRESS = 2'b10;
    localparam ST_CONFIGURED = 2'b11;
    // counters are 23 bits wide; cut the timing parameters on purpose
    localparam [22:0] IDLE_LAST = SUSPEND_CYCLES - 1;
    localparam [22:0] K_LOAD = RESUME_K_CYCLES;

    reg [31:0] global_state;
    reg [31:0] func_addr;
    reg [31:0] irq_mask;
    reg [31:0] irq_status;
    reg [31:0] transceiver;
    reg [22:0] idle_count;
    reg [22:0] k_count;
    reg suspended;
    reg resume_meta;
    reg resume_sync;
    reg resume_seen;
    reg [1:0] next_state;
    reg [31:0] rd_mux;
    wire [31:0] ep_ctrl [0:7];
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = req && wb_we_i && (wb_sel_i == 4'hF);
    wire wr_gs = wr && wb_adr_i == `OFS_GLOBAL_STATE;
    wire wr_clear = wr && wb_adr_i == `OFS_IRQ_CLEAR;
    wire wr_reset_ep = wr && wb_adr_i == `OFS_RESET_EP;
    wire [7:0] ep_ofs = wb_adr_i - `OFS_EP_CTRL0;
    wire ep_hit = wb_adr_i >= `OFS_EP_CTRL0 && wb_adr_i <= `OFS_EP_CTRL7 &&
                  ep_ofs[1:0] == 2'b00;
    wire idle_done = idle_count == IDLE_LAST;
    wire resume_rise = resume_sync && !resume_seen;
    wire start_resume = wr_gs && wb_dat_i[`GS_SEND_RESUME] &&
                        !global_state[`GS_SEND_RESUME] &&
                        global_state[`GS_REMOTE_WAKE];

    ////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_ep
            localparam [2:0] EP_IDX = i;
            usb_ep_ctrl u_ep (
                .clk_sys(clk_sys),
                .rst(rst),
                .bus_reset_end(bus_reset_end),
                .ep_reset(wr_reset_ep && wb_dat_i[i]),
                .wr(wr && ep_hit && ep_ofs[4:2] == EP_IDX),
                .wdata(wb_dat_i),
                .ctrl(ep_ctrl[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // wishbone slave: ack one cycle after request, then drop
    always @* begin
        case (wb_adr_i)
            `OFS_GLOBAL_STATE: rd_mux = global_state;
            `OFS_FUNC_ADDR: rd_mux = func_addr;
            `OFS_IRQ_MASK: rd_mux = irq_mask;
            `OFS_IRQ_STATUS: rd_mux = irq_status;
            `OFS_TRANSCEIVER: rd_mux = transceiver;
            `OFS_BUS_EVENT: rd_mux = {31'h0, suspended};
            default: begin
                if (ep_hit)
                    rd_mux = ep_ctrl[ep_ofs[4:2]];
                else
                    rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////
    // state derived from bus reset and firmware writes
    always @* begin
        next_state = device_state;
        if (!transceiver[`TX_PULLUP])
            next_state = ST_POWERED;
        else if (bus_reset_end)
            next_state = ST_DEFAULT;
        else if (global_state[`GS_CONFIGURED])
            next_state = ST_CONFIGURED;
        else if (global_state[`GS_ADDRESSED])
            next_state = ST_ADDRESS;
        else if (device_state != ST_POWERED)
            next_state = ST_DEFAULT;
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            global_state <= `RST_GLOBAL_STATE;
            func_addr <= `RST_FUNC_ADDR;
            transceiver <= `RST_TRANSCEIVER;
            device_state <= ST_POWERED;
            k_count <= 23'h000000;
        end else begin
            device_state <= next_state;
            if (bus_reset_end) begin
                global_state[`GS_ADDRESSED] <= 1'b0;
                global_state[`GS_CONFIGURED] <= 1'b0;
                func_addr <= `RST_FUNC_ADDR;
            end else if (wr_gs) begin
                // a zero write cannot leave address state
                if (wb_dat_i[`GS_ADDRESSED])
                    global_state[`GS_ADDRESSED] <= 1'b1;
                global_state[`GS_CONFIGURED] <= wb_dat_i[`GS_CONFIGURED];
                global_state[`GS_SEND_RESUME] <= wb_dat_i[`GS_SEND_RESUME];
                global_state[`GS_REMOTE_WAKE] <= wb_dat_i[`GS_REMOTE_WAKE];
            end
            if (wr && wb_adr_i == `OFS_FUNC_ADDR && !bus_reset_end)
                func_addr <= {23'h0, wb_dat_i[`FA_VALID], 1'b0, wb_dat_i[6:0]};
            if (wr && wb_adr_i == `OFS_TRANSCEIVER)
                transceiver <= {22'h0, wb_dat_i[`TX_PULLUP], wb_dat_i[`TX_DISABLE], 8'h00};
            // k state timer runs on its own once started
            if (start_resume) begin
                k_count <= K_LOAD;
                global_state[`GS_RESUME_BUSY] <= 1'b1;
            end else if (k_count != 23'h000000) begin
                k_count <= k_count - 23'h000001;
                if (k_count == 23'h000001)
                    global_state[`GS_RESUME_BUSY] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // resume line may change with clocks slowed; sync before use
    always @(posedge clk_sys) begin
        if (rst) begin
            resume_meta <= 1'b0;
            resume_sync <= 1'b0;
            resume_seen <= 1'b0;
        end else begin
            resume_meta <= resume_detect;
            resume_sync <= resume_meta;
            resume_seen <= resume_sync;
        end
    end

    always @(posedge clk_sys) begin
        if (rst || bus_activity || bus_reset_end) begin
            idle_count <= 23'h000000;
            suspended <= 1'b0;
        end else if (!transceiver[`TX_PULLUP]) begin
            idle_count <= 23'h000000;
        end else if (!suspended) begin
            if (idle_done)
                suspended <= 1'b1;
            else
                idle_count <= idle_count + 23'h000001;
        end else if (resume_rise) begin
            suspended <= 1'b0;
            idle_count <= 23'h000000;
        end
    end

    ////////////////////////////////////////////////////////////////
    // interrupt status: set wins over clear
    always @(posedge clk_sys) begin
        if (rst) begin
            irq_status <= 32'h0000_0000;
            irq_mask <= `RST_IRQ_MASK;
        end else begin
            if (wr_clear)
                irq_status <= irq_status & ~wb_dat_i;
            if (!suspended && idle_done && !bus_activity && transceiver[`TX_PULLUP])
                irq_status[`IRQ_SUSPEND] <= 1'b1;
            if (suspended && resume_rise)
                irq_status[`IRQ_WAKEUP] <= 1'b1;
            if (bus_reset_end)
                irq_status[`IRQ_BUS_RESET_END] <= 1'b1;
            if (bus_reset_end)
                irq_mask <= `RST_IRQ_MASK;
            else if (wr && wb_adr_i == `OFS_IRQ_ENABLE)
                irq_mask <= irq_mask | wb_dat_i;
            else if (wr && wb_adr_i == `OFS_IRQ_DISABLE)
                irq_mask <= irq_mask & ~wb_dat_i;
        end
    end

    ////////////////////////////////////////////////////////////////
    // registered outputs
    always @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
            drive_k_state <= 1'b0;
            pullup_connected <= 1'b0;
            transceiver_off <= 1'b1;
            device_address <= 7'h00;
            address_valid <= 1'b0;
            endpoint_enables <= 8'h00;
        end else begin
            irq <= irq_status[`IRQ_BUS_RESET_END] ||
                   (|(irq_status[`IRQ_WAKEUP:0] & irq_mask[`IRQ_WAKEUP:0]));
            drive_k_state <= k_count != 23'h000000;
            pullup_connected <= transceiver[`TX_PULLUP];
            transceiver_off <= transceiver[`TX_DISABLE];
            device_address <= func_addr[6:0];
            address_valid <= func_addr[`FA_VALID];
            endpoint_enables <= {ep_ctrl[7][`EP_ENABLE], ep_ctrl[6][`EP_ENABLE],
                                 ep_ctrl[5][`EP_ENABLE], ep_ctrl[4][`EP_ENABLE],
                                 ep_ctrl[3][`EP_ENABLE], ep_ctrl[2][`EP_ENABLE],
                                 ep_ctrl[1][`EP_ENABLE], ep_ctrl[0][`EP_ENABLE]};
        end
    end
endmodule // usb_device_state_control

/* File: tb/usb_state_checker.sv */
`timescale 1ns/1ps
`include "usb_state_consts.vh"
module usb_state_checker #(
    parameter RESUME_K_CYCLES = 20
) (
    input wire clk_sys,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    input wire bus_reset_end,
    input wire drive_k_state,
    input wire pullup_connected,
    input wire irq,
    input wire [6:0] device_address,
    input wire [1:0] device_state,
    input wire [7:0] endpoint_enables
);
default clocking cb @(posedge clk_sys);
endclocking
default disable iff (rst);
wire wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i == 4'hF;
wire wr_k = wr && wb_adr_i == `OFS_GLOBAL_STATE && wb_dat_i[2] && wb_dat_i[4];
reg [31:0] k_len;
// cycles the current K burst has lasted
always @(posedge clk_sys) begin
    if (rst || !drive_k_state)
        k_len <= 32'h0;
    else
        k_len <= k_len + 32'h1;
end
////////////////////////////////////////////////////////////////////////////////
sequence s_default;
    ##2 (device_state == 2'h1 && endpoint_enables == 8'h00);
endsequence
property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
a_ack: assert property (p_ack) else $error("ack held");
property p_pull; wr && wb_adr_i == `OFS_TRANSCEIVER |-> ##2 pullup_connected == $past(wb_dat_i[9], 2); endproperty
a_pull: assert property (p_pull) else $error("pullup wrong");
property p_addr; wr && wb_adr_i == `OFS_FUNC_ADDR |-> ##2 device_address == $past(wb_dat_i[6:0], 2); endproperty
a_addr: assert property (p_addr) else $error("address wrong");
property p_dflt; bus_reset_end |-> s_default; endproperty
a_dflt: assert property (p_dflt) else $error("no default state");
property p_breirq; bus_reset_end |-> ##[1:3] irq; endproperty
a_breirq: assert property (p_breirq) else $error("no reset irq");
property p_stay; device_state[1] && !bus_reset_end && !$past(bus_reset_end) |=> device_state != 2'h1; endproperty
a_stay: assert property (p_stay) else $error("left address state");
property p_kgo; $rose(drive_k_state) |-> $past(wr_k) || $past(wr_k, 2); endproperty
a_kgo: assert property (p_kgo) else $error("K without trigger");
property p_klen; $fell(drive_k_state) |-> k_len == RESUME_K_CYCLES; endproperty
a_klen: assert property (p_klen) else $error("K length wrong");
endmodule // usb_state_checker
bind usb_device_state_control usb_state_checker #(.RESUME_K_CYCLES(RESUME_K_CYCLES)) i_chk (.*);

/* File: tb/usb_host_model.sv */
`timescale 1ns/1ps
module usb_host_model (
    input wire clk_sys,
    input wire drive_k_state,
    output reg bus_activity,
    output reg bus_reset_end,
    output reg resume_detect
);
initial begin
    bus_activity = 1'h1;
    bus_reset_end = 1'h0;
    resume_detect = 1'h0;
end
// a device K burst is bus traffic too
always @(posedge clk_sys) begin
    if (drive_k_state)
        bus_activity <= 1'h1;
end
////////////////////////////////////////////////////////////////////////////////
task bus_reset;
    @(posedge clk_sys);
    bus_reset_end <= 1'h1;
    @(posedge clk_sys);
    bus_reset_end <= 1'h0;
endtask
task set_idle(input logic on);
    @(posedge clk_sys);
    bus_activity <= !on;
endtask
task host_resume;
    @(posedge clk_sys);
    resume_detect <= 1'h1;
    repeat (4) @(posedge clk_sys);
    resume_detect <= 1'h0;
    bus_activity <= 1'h1;
endtask
endmodule // usb_host_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "usb_state_consts.vh"
module tb_top;
localparam SUS = 50;
localparam RK = 20;
reg clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i;
reg [7:0] wb_adr_i;
reg [3:0] wb_sel_i;
reg [31:0] wb_dat_i;
wire [31:0] wb_dat_o;
wire wb_ack_o, bus_activity, bus_reset_end, resume_detect, drive_k_state;
wire pullup_connected, transceiver_off, irq, address_valid;
wire [6:0] device_address;
wire [1:0] device_state;
wire [7:0] endpoint_enables;
integer errors, num_checks, n;
logic [31:0] q;
usb_device_state_control #(.SUSPEND_CYCLES(SUS), .RESUME_K_CYCLES(RK)) i_dut (.*);
usb_host_model i_host (.*);
initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
end
////////////////////////////////////////////////////////////////////////////////
task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
        errors = errors + 1;
        $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
endtask
task finish_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
// request held until ack is sampled high
task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
        @(posedge clk_sys);
        n = n + 1;
    end while (wb_ack_o !== 1'h1 && n < 50);
    if (wb_ack_o !== 1'h1) begin
        errors = errors + 1;
        finish_test;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    // registered outputs follow the stored register one edge later
    @(posedge clk_sys);
endtask
task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    check($sformatf("reg %h", a), q, e);
endtask
////////////////////////////////////////////////////////////////////////////////
task test_attach;
    rd(`OFS_GLOBAL_STATE, `RST_GLOBAL_STATE);
    check("txoff", transceiver_off, 1'h1);
    rd(`OFS_FUNC_ADDR, `RST_FUNC_ADDR);
    rd(8'h0C, 32'h0);
    wb(1'h1, `OFS_TRANSCEIVER, 32'h0000_0200);
    check("pullup", pullup_connected, 1'h1);
    check("state", device_state, 2'h0);
    check("txoff", transceiver_off, 1'h0);
    wb(1'h1, `OFS_EP_CTRL0, 32'h0000_8000);
    wb(1'h1, `OFS_IRQ_ENABLE, 32'h0000_0001);
    i_host.bus_reset;
    repeat (3) @(posedge clk_sys);
    check("state", device_state, 2'h1);
    check("irq", irq, 1'h1);
    check("ep", endpoint_enables, 8'h00);
    rd(`OFS_IRQ_MASK, `RST_IRQ_MASK);
    rd(`OFS_IRQ_STATUS, 32'h0000_1000);
    wb(1'h1, `OFS_IRQ_CLEAR, 32'h0000_1000);
    rd(`OFS_IRQ_STATUS, 32'h0);
    wb(1'h1, `OFS_EP_CTRL0, 32'h0000_8000);
    wb(1'h1, `OFS_IRQ_ENABLE, 32'h0000_0001);
    check("ep", endpoint_enables, 8'h01);
    rd(`OFS_IRQ_MASK, 32'h0000_1201);
    $display("done attach");
endtask
task test_cancel;
    wb(1'h1, 8'h34, 32'h0000_8010);
    rd(8'h34, 32'h0000_8010);
    wb(1'h1, 8'h34, 32'h0000_8000);
    rd(8'h34, 32'h0000_8000);
    wb(1'h1, 8'h34, 32'h0000_8010);
    rd(8'h34, 32'h0000_8010);
    wb(1'h1, 8'h34, 32'h0000_8000);
    wb(1'h1, `OFS_RESET_EP, 32'h0000_0002);
    rd(8'h34, 32'h0000_8000);
    wb(1'h1, 8'h34, 32'h0000_8010);
    wb(1'h1, `OFS_RESET_EP, 32'h0000_0002);
    rd(8'h34, 32'h0000_8000);
    check("ep", endpoint_enables, 8'h03);
    $display("done cancel");
endtask
task test_address;
    wb(1'h1, `OFS_FUNC_ADDR, 32'h0000_0105);
    wb(1'h1, `OFS_GLOBAL_STATE, 32'h0000_0001);
    check("addr", device_address, 7'h05);
    check("valid", address_valid, 1'h1);
    check("state", device_state, 2'h2);
    wb(1'h1, `OFS_GLOBAL_STATE, 32'h0);
    check("state", device_state, 2'h2);
    wb(1'h1, `OFS_GLOBAL_STATE, 32'h0000_0003);
    check("state", device_state, 2'h3);
    $display("done address");
endtask
task test_suspend;
    i_host.set_idle(1'h1);
    repeat (SUS - 10) @(posedge clk_sys);
    rd(`OFS_IRQ_STATUS, 32'h0);
    repeat (20) @(posedge clk_sys);
    rd(`OFS_IRQ_STATUS, 32'h0000_0100);
    check("irq", irq, 1'h0);
    wb(1'h1, `OFS_IRQ_ENABLE, 32'h0000_2100);
    rd(`OFS_IRQ_STATUS, 32'h0000_0100);
    check("irq", irq, 1'h1);
    i_host.host_resume;
    repeat (4) @(posedge clk_sys);
    rd(`OFS_IRQ_STATUS, 32'h0000_2100);
    wb(1'h1, `OFS_IRQ_CLEAR, 32'h0000_2100);
    rd(`OFS_IRQ_STATUS, 32'h0);
    $display("done suspend");
endtask
task test_wake;
    wb(1'h1, `OFS_GLOBAL_STATE, 32'h0000_0007);
    repeat (3) @(posedge clk_sys);
    check("k", drive_k_state, 1'h0);
    wb(1'h1, `OFS_GLOBAL_STATE, 32'h0000_0013);
    wb(1'h1, `OFS_GLOBAL_STATE, 32'h0000_0017);
    for (n = 0; drive_k_state !== 1'h1 && n < 5; n = n + 1)
        @(posedge clk_sys);
    check("k", drive_k_state, 1'h1);
    for (n = 0; drive_k_state === 1'h1 && n < 100; n = n + 1)
        @(posedge clk_sys);
    check("klen", n, RK);
    wb(1'h1, `OFS_GLOBAL_STATE, 32'h0000_0017);
    repeat (3) @(posedge clk_sys);
    check("k", drive_k_state, 1'h0);
    i_host.bus_reset;
    repeat (3) @(posedge clk_sys);
    check("state", device_state, 2'h1);
    $display("done wake");
endtask
initial begin
    errors = 0;
    num_checks = 0;
    rst = 1'h1;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'h0;
    test_attach;
    test_cancel;
    test_address;
    test_suspend;
    test_wake;
    finish_test;
end
endmodule // tb_top
